// ==== verilog/css_switcher.sv ====
// clock source switcher: unlockable control register, switch sequencer
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module css_switcher (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire css_pkg::css_apb_req_t apb_req,
   output css_pkg::css_apb_rsp_t apb_rsp,
   // oscillator pins: clocks, start-up/lock ready, demand, failure
   input wire logic [css_pkg::CSS_NOSC-1:0] osc_clk,
   input wire logic [css_pkg::CSS_NOSC-1:0] osc_ready,
   input wire logic secondary_osc_periph_req,
   input wire logic clk_fail,
   // oscillator controls
   output logic [css_pkg::CSS_NOSC-1:0] osc_en,
   output logic [2:0] sys_clk_sel,
   output logic secondary_osc_digital_io,
   output logic secondary_osc_low_drive,
   output logic secondary_osc_ext_clk
);
   import css_pkg::*;

   css_state_t s_q;
   css_state_t s_d;
   logic [CSS_SYNC_W-1:0] pins_s;
   logic [CSS_NOSC-1:0] clk_s;
   logic [CSS_NOSC-1:0] rdy_s;
   logic sreq_s;
   logic fail_s;

   css_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({osc_clk, osc_ready, secondary_osc_periph_req, clk_fail}),
      .sync_out(pins_s)
   );

   assign clk_s = pins_s[11:7];
   assign rdy_s = pins_s[6:2];
   assign sreq_s = pins_s[1];
   assign fail_s = pins_s[0];

   // physical oscillators a source code needs running
   function automatic logic [CSS_NOSC-1:0] need_of(input logic [2:0] src);
      logic [CSS_NOSC-1:0] n;
      n = '0;
      unique case (src)
         CSS_SRC_FAST_RC_MULTIPLIED: begin
            n[CSS_O_FRC] = 1'b1;
            n[CSS_O_PLL] = 1'b1;
         end
         CSS_SRC_PRI: n[CSS_O_PRI] = 1'b1;
         CSS_SRC_PRIPLL: begin
            n[CSS_O_PRI] = 1'b1;
            n[CSS_O_PLL] = 1'b1;
         end
         CSS_SRC_SEC: n[CSS_O_SEC] = 1'b1;
         CSS_SRC_LOW_POWER_RC: n[CSS_O_LOW_POWER_RC] = 1'b1;
         default: n[CSS_O_FRC] = 1'b1;
      endcase
      return n;
   endfunction

   // oscillator whose output becomes the system clock
   function automatic int clk_idx(input logic [2:0] src);
      int i;
      i = CSS_O_FRC;
      unique case (src)
         CSS_SRC_FAST_RC_MULTIPLIED, CSS_SRC_PRIPLL: i = CSS_O_PLL;
         CSS_SRC_PRI: i = CSS_O_PRI;
         CSS_SRC_SEC: i = CSS_O_SEC;
         CSS_SRC_LOW_POWER_RC: i = CSS_O_LOW_POWER_RC;
         default: i = CSS_O_FRC;
      endcase
      return i;
   endfunction

   logic acc;
   logic wr;
   logic sw_on;
   logic fail_safe_monitor_on;
   logic secondary_osc_xtal_mode;
   logic [7:0] hi_b;
   logic [7:0] lo_b;
   logic [CSS_NOSC-1:0] rdy_eff;
   logic [CSS_NOSC-1:0] need_tgt;
   logic new_clk;
   logic new_edge;
   logic [15:0] osc_rd;
   logic [31:0] cfg_rd;
   logic [31:0] stat_rd;

   always_comb begin
      s_d = s_q;
      acc = apb_req.psel && apb_req.penable && s_q.rsp.pready;
      wr = acc && apb_req.pwrite;
      hi_b = apb_req.pwdata[15:8];
      lo_b = apb_req.pwdata[7:0];
      sw_on = (s_q.sw_cfg == CSS_SWCFG_ON);
      fail_safe_monitor_on = sw_on;
      // rc sources need no start-up wait; an external secondary clock neither
      rdy_eff = rdy_s | CSS_RC_MASK;
      if (s_q.secondary_osc_mode == CSS_SMODE_EXTCLK) begin
         rdy_eff[CSS_O_SEC] = 1'b1;
      end
      need_tgt = need_of(s_q.nxt);
      new_clk = clk_s[clk_idx(s_q.nxt)];
      new_edge = new_clk && !s_q.clk_prev;
      s_d.clk_prev = new_clk;

      // register read images
      osc_rd = '0;
      osc_rd[CSS_CUR_LSB +: 3] = s_q.cur;
      osc_rd[CSS_NXT_LSB +: 3] = s_q.nxt;
      osc_rd[CSS_LOCK_BIT] = s_q.lock;
      osc_rd[CSS_CF_BIT] = s_q.cf;
      osc_rd[CSS_SECONDARY_OSC_ENABLE_BIT] = s_q.secondary_osc_en;
      osc_rd[CSS_REQ_BIT] = s_q.req;
      cfg_rd = '0;
      cfg_rd[CSS_CFG_SW_LSB +: 2] = s_q.sw_cfg;
      cfg_rd[CSS_CFG_INIT_LSB +: 3] = s_q.init_src;
      cfg_rd[CSS_CFG_SMODE_LSB +: 2] = s_q.secondary_osc_mode;
      cfg_rd[CSS_CFG_WDT_BIT] = s_q.wdt_en;
      stat_rd = '0;
      stat_rd[CSS_ST_EN_LSB +: CSS_NOSC] = s_q.osc_en;
      stat_rd[CSS_ST_RDY_LSB +: CSS_NOSC] = rdy_s;

      // apb: answer in the first access cycle, data sampled at setup
      s_d.rsp.pready = apb_req.psel && !apb_req.penable;
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata = '0;
      if (apb_req.psel && !apb_req.penable) begin
         unique case (apb_req.paddr)
            CSS_OFF_OSC: s_d.rsp.prdata = {16'h0000, osc_rd};
            CSS_OFF_CFG: s_d.rsp.prdata = cfg_rd;
            CSS_OFF_STAT: s_d.rsp.prdata = stat_rd;
            default: s_d.rsp.pslverr = 1'b1;
         endcase
      end

      // any completed access drops a pending unlock
      if (acc) begin
         s_d.key_hi = CSS_UNL_IDLE;
         s_d.key_lo = CSS_UNL_IDLE;
      end

      if (wr && apb_req.paddr == CSS_OFF_OSC) begin
         if (apb_req.pstrb[1]) begin
            if (s_q.key_hi == CSS_UNL_ARMED) begin
               s_d.nxt = hi_b[CSS_NXT_LSB-8 +: 3];
            end else if (hi_b == CSS_KEY_HI1) begin
               s_d.key_hi = CSS_UNL_FIRST;
            end else if (s_q.key_hi == CSS_UNL_FIRST && hi_b == CSS_KEY_HI2) begin
               s_d.key_hi = CSS_UNL_ARMED;
            end
         end
         if (apb_req.pstrb[0]) begin
            if (s_q.key_lo == CSS_UNL_ARMED) begin
               s_d.secondary_osc_en = lo_b[CSS_SECONDARY_OSC_ENABLE_BIT];
               if (!lo_b[CSS_CF_BIT]) begin
                  s_d.cf = 1'b0;
               end
               // request only accepted while switching is enabled
               if (lo_b[CSS_REQ_BIT] && sw_on) begin
                  s_d.req = 1'b1;
               end
            end else if (lo_b == CSS_KEY_LO1) begin
               s_d.key_lo = CSS_UNL_FIRST;
            end else if (s_q.key_lo == CSS_UNL_FIRST && lo_b == CSS_KEY_LO2) begin
               s_d.key_lo = CSS_UNL_ARMED;
            end
         end
      end

      if (wr && apb_req.paddr == CSS_OFF_CFG) begin
         if (apb_req.pstrb[0]) begin
            s_d.sw_cfg = apb_req.pwdata[CSS_CFG_SW_LSB +: 2];
            s_d.init_src = apb_req.pwdata[CSS_CFG_INIT_LSB +: 3];
            s_d.secondary_osc_mode = apb_req.pwdata[CSS_CFG_SMODE_LSB +: 2];
         end
         if (apb_req.pstrb[1]) begin
            s_d.wdt_en = apb_req.pwdata[CSS_CFG_WDT_BIT];
         end
      end

      // sequencer runs beside the bus; nothing here holds pready back
      unique case (s_q.fsm)
         CSS_IDLE: begin
            if (s_q.req) begin
               s_d.fsm = CSS_CHECK;
            end
         end
         CSS_CHECK: begin
            if (s_q.nxt == s_q.cur) begin
               s_d.req = 1'b0;
               s_d.fsm = CSS_IDLE;
            end else begin
               s_d.lock = 1'b0;
               s_d.cf = 1'b0;
               s_d.fsm = CSS_WAIT;
            end
         end
         CSS_WAIT: begin
            // crystal waits for start-up timer, multiplier for lock
            if ((rdy_eff & need_tgt) == need_tgt) begin
               s_d.cnt = '0;
               s_d.fsm = CSS_COUNT;
            end
         end
         CSS_COUNT: begin
            // edges are sampled at pclk, so the new clock must be slower than pclk/2
            if (new_edge) begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == CSS_SWITCH_CYC - 4'h1) begin
                  s_d.clk_sel = s_q.nxt;
                  s_d.cur = s_q.nxt;
                  s_d.req = 1'b0;
                  s_d.fsm = CSS_IDLE;
               end
            end
         end
      endcase

      // with switching off the request stays low and the strap picks the clock
      if (!sw_on) begin
         s_d.req = 1'b0;
         s_d.fsm = CSS_IDLE;
         s_d.cur = s_q.init_src;
         s_d.clk_sel = s_q.init_src;
      end

      // status flags: fail set wins over a clear in the same cycle; lock is never set in CHECK, so the switch's clear wins
      if (s_q.fsm != CSS_CHECK) begin
         if (rdy_s[CSS_O_PLL] && s_q.osc_en[CSS_O_PLL]) begin
            s_d.lock = 1'b1;
         end else if (!rdy_s[CSS_O_PLL]) begin
            s_d.lock = 1'b0;
         end
      end
      if (fail_s && fail_safe_monitor_on) begin
         s_d.cf = 1'b1;
      end

      // the running source, and the target while switching, stay on; low-power rc and secondary can also be forced on below
      s_d.osc_en = need_of(s_d.cur);
      if (s_d.fsm == CSS_WAIT || s_d.fsm == CSS_COUNT) begin
         s_d.osc_en = s_d.osc_en | need_of(s_d.nxt);
      end
      if (s_d.wdt_en || (s_d.sw_cfg == CSS_SWCFG_ON)) begin
         s_d.osc_en[CSS_O_LOW_POWER_RC] = 1'b1;
      end
      if (s_d.secondary_osc_en || sreq_s) begin
         s_d.osc_en[CSS_O_SEC] = 1'b1;
      end
      // crystal driver off in digital-pin and external-clock modes
      secondary_osc_xtal_mode = (s_d.secondary_osc_mode == CSS_SMODE_RST) ||
                       (s_d.secondary_osc_mode == CSS_SMODE_LOWPWR);
      if (!secondary_osc_xtal_mode) begin
         s_d.osc_en[CSS_O_SEC] = 1'b0;
      end
      // all three mode outputs come from one mode value, so they never overlap
      s_d.secondary_osc_digital = (s_d.secondary_osc_mode == CSS_SMODE_DIG);
      s_d.secondary_osc_low_drive = (s_d.secondary_osc_mode == CSS_SMODE_LOWPWR);
      s_d.secondary_osc_ext_clk = (s_d.secondary_osc_mode == CSS_SMODE_EXTCLK);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.fsm <= CSS_IDLE;
         s_q.cur <= CSS_SRC_RST;
         s_q.nxt <= CSS_SRC_RST;
         s_q.req <= 1'b0;
         s_q.lock <= 1'b0;
         s_q.cf <= 1'b0;
         s_q.secondary_osc_en <= 1'b0;
         s_q.key_hi <= CSS_UNL_IDLE;
         s_q.key_lo <= CSS_UNL_IDLE;
         s_q.cnt <= '0;
         s_q.clk_prev <= 1'b0;
         s_q.sw_cfg <= CSS_SWCFG_RST;
         s_q.init_src <= CSS_SRC_RST;
         s_q.secondary_osc_mode <= CSS_SMODE_RST;
         s_q.wdt_en <= 1'b0;
         s_q.clk_sel <= CSS_SRC_RST;
         s_q.osc_en <= CSS_OSC_EN_RST;
         s_q.secondary_osc_digital <= 1'b0;
         s_q.secondary_osc_low_drive <= 1'b0;
         s_q.secondary_osc_ext_clk <= 1'b0;
         s_q.rsp <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign osc_en = s_q.osc_en;
   assign sys_clk_sel = s_q.clk_sel;
   assign secondary_osc_digital_io = s_q.secondary_osc_digital;
   assign secondary_osc_low_drive = s_q.secondary_osc_low_drive;
   assign secondary_osc_ext_clk = s_q.secondary_osc_ext_clk;
endmodule
`default_nettype wire

// ==== inc/css_pkg.sv ====
// package: constants and types for the clock source switcher
// What this block does
// - high byte writable after keys 78h, 9Ah
// - low byte writable after keys 46h, 57h
// - unlocked high-byte write sets next-source bits 10:8
// - current source shown in bits 14:12
// - unlocked low-byte write sets request bit 0
// - same source requested: clear request, abort
// - valid switch clears lock and fail flags
// - enable target; wait start-up or lock
// - count ten new-clock cycles before switching
// - done: clear request, copy next to current
// - power old source down, with stated exceptions
// - switching never stalls instruction execution
// - peripheral demand or enable starts secondary oscillator
// - secondary mode 11/01 oscillator, 00 digital pins
// - secondary mode 01 selects low drive
// - digital mode 00 and external-clock mode 10: no crystal, enable ignored
// - switching disabled unless config is 00
package css_pkg;

   // register byte offsets
   localparam logic [7:0] CSS_OFF_OSC = 8'h00;
   localparam logic [7:0] CSS_OFF_CFG = 8'h04;
   localparam logic [7:0] CSS_OFF_STAT = 8'h08;

   // unlock keys
   localparam logic [7:0] CSS_KEY_HI1 = 8'h78;
   localparam logic [7:0] CSS_KEY_HI2 = 8'h9a;
   localparam logic [7:0] CSS_KEY_LO1 = 8'h46;
   localparam logic [7:0] CSS_KEY_LO2 = 8'h57;
   localparam logic [1:0] CSS_UNL_IDLE = 2'h0;
   localparam logic [1:0] CSS_UNL_FIRST = 2'h1;
   localparam logic [1:0] CSS_UNL_ARMED = 2'h2;

   // osc_control_reg field positions
   localparam int CSS_CUR_LSB = 12;
   localparam int CSS_NXT_LSB = 8;
   localparam int CSS_LOCK_BIT = 5;
   localparam int CSS_CF_BIT = 3;
   localparam int CSS_SECONDARY_OSC_ENABLE_BIT = 1;
   localparam int CSS_REQ_BIT = 0;

   // configuration register field positions
   localparam int CSS_CFG_SW_LSB = 0;
   localparam int CSS_CFG_INIT_LSB = 2;
   localparam int CSS_CFG_SMODE_LSB = 5;
   localparam int CSS_CFG_WDT_BIT = 8;

   // status register field positions
   localparam int CSS_ST_EN_LSB = 0;
   localparam int CSS_ST_RDY_LSB = 8;

   // configuration codes and reset values
   localparam logic [1:0] CSS_SWCFG_ON = 2'h0;
   localparam logic [1:0] CSS_SWCFG_RST = 2'h3;
   localparam logic [1:0] CSS_SMODE_DIG = 2'h0;
   localparam logic [1:0] CSS_SMODE_LOWPWR = 2'h1;
   localparam logic [1:0] CSS_SMODE_EXTCLK = 2'h2;
   localparam logic [1:0] CSS_SMODE_RST = 2'h3;
   localparam logic [2:0] CSS_SRC_RST = 3'h0;

   // clock source codes
   localparam logic [2:0] CSS_SRC_FRC = 3'h0;
   localparam logic [2:0] CSS_SRC_FAST_RC_MULTIPLIED = 3'h1;
   localparam logic [2:0] CSS_SRC_PRI = 3'h2;
   localparam logic [2:0] CSS_SRC_PRIPLL = 3'h3;
   localparam logic [2:0] CSS_SRC_SEC = 3'h4;
   localparam logic [2:0] CSS_SRC_LOW_POWER_RC = 3'h5;

   // physical oscillators, one bit each
   localparam int CSS_NOSC = 5;
   localparam int CSS_O_FRC = 0;
   localparam int CSS_O_PRI = 1;
   localparam int CSS_O_SEC = 2;
   localparam int CSS_O_LOW_POWER_RC = 3;
   localparam int CSS_O_PLL = 4;
   localparam logic [4:0] CSS_RC_MASK = 5'h09;
   localparam logic [4:0] CSS_OSC_EN_RST = 5'h01;

   // new-clock cycles counted before the switch
   localparam logic [3:0] CSS_SWITCH_CYC = 4'ha;

   // synchroniser: osc clocks, ready flags, sec request, fail
   localparam int CSS_SYNC_W = 12;

   typedef enum logic [1:0] {
      CSS_IDLE,
      CSS_CHECK,
      CSS_WAIT,
      CSS_COUNT
   } css_fsm_t;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } css_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } css_apb_rsp_t;

   typedef struct packed {
      logic [CSS_SYNC_W-1:0] meta;
      logic [CSS_SYNC_W-1:0] sync;
   } css_sync_t;

   typedef struct packed {
      css_fsm_t fsm;
      logic [2:0] cur;
      logic [2:0] nxt;
      logic req;
      logic lock;
      logic cf;
      logic secondary_osc_en;
      logic [1:0] key_hi;
      logic [1:0] key_lo;
      logic [3:0] cnt;
      logic clk_prev;
      logic [1:0] sw_cfg;
      logic [2:0] init_src;
      logic [1:0] secondary_osc_mode;
      logic wdt_en;
      logic [2:0] clk_sel;
      logic [4:0] osc_en;
      logic secondary_osc_digital;
      logic secondary_osc_low_drive;
      logic secondary_osc_ext_clk;
      css_apb_rsp_t rsp;
   } css_state_t;

endpackage

// ==== verilog/css_sync.sv ====
// two-flop synchroniser for the pin inputs of the switcher
`timescale 1ns/1ps
`default_nettype none
module css_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous inputs and synchronised copies
   input wire logic [css_pkg::CSS_SYNC_W-1:0] async_in,
   output logic [css_pkg::CSS_SYNC_W-1:0] sync_out
);
   import css_pkg::*;

   css_sync_t s_q;
   css_sync_t s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d.meta = async_in;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.sync;
endmodule
`default_nettype wire

// ==== sim/css_monitor.sv ====
// assertion checker watching the clock source switcher ports
`timescale 1ns/1ps
`default_nettype none
module css_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire css_pkg::css_apb_req_t apb_req,
   input wire css_pkg::css_apb_rsp_t apb_rsp,
   // oscillator pins
   input wire logic [css_pkg::CSS_NOSC-1:0] osc_clk,
   input wire logic [css_pkg::CSS_NOSC-1:0] osc_ready,
   input wire logic secondary_osc_periph_req,
   input wire logic clk_fail,
   // oscillator controls
   input wire logic [css_pkg::CSS_NOSC-1:0] osc_en,
   input wire logic [2:0] sys_clk_sel,
   input wire logic secondary_osc_digital_io,
   input wire logic secondary_osc_low_drive,
   input wire logic secondary_osc_ext_clk
);
   import css_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup;
   logic mapped;
   assign setup = apb_req.psel && !apb_req.penable;
   assign mapped = apb_req.paddr inside {CSS_OFF_OSC, CSS_OFF_CFG, CSS_OFF_STAT};

   a_pready_next: assert property (setup |=> apb_rsp.pready)
      else $error("pready missing after setup");
   a_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   a_unmapped_err: assert property (setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (apb_rsp.pready && apb_req.paddr == CSS_OFF_OSC
      |-> apb_rsp.prdata[31:16] == 16'h0)
      else $error("control register upper half not zero");
   a_secondary_osc_modes: assert property ($onehot0({secondary_osc_digital_io, secondary_osc_low_drive, secondary_osc_ext_clk}))
      else $error("secondary mode outputs overlap");
   a_sel_enabled: assert property ($changed(sys_clk_sel) && sys_clk_sel == CSS_SRC_PRI
      |-> $past(osc_en[CSS_O_PRI]))
      else $error("switched onto a primary source that was off");
   a_old_off: assert property ($changed(sys_clk_sel) && $past(sys_clk_sel) == CSS_SRC_FRC
      && sys_clk_sel != CSS_SRC_FAST_RC_MULTIPLIED |-> ##[0:2] !osc_en[CSS_O_FRC])
      else $error("old fast rc source left running");
   a_periph_on: assert property ($rose(secondary_osc_periph_req) && !secondary_osc_digital_io && !secondary_osc_ext_clk
      |-> ##[1:4] osc_en[CSS_O_SEC])
      else $error("secondary oscillator not started on demand");

   c_switch: cover property ($changed(sys_clk_sel) && sys_clk_sel == CSS_SRC_PRI);
   c_refused: cover property (apb_rsp.pslverr);
   c_low_drive: cover property (secondary_osc_low_drive);
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// testbench for the clock source switcher
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import css_pkg::*;
   logic pclk;
   logic presetn;
   css_apb_req_t apb_req;
   css_apb_rsp_t apb_rsp;
   logic [4:0] osc_clk = 5'h00;
   logic [4:0] osc_ready;
   logic secondary_osc_periph_req;
   logic clk_fail;
   logic [4:0] osc_en;
   logic [2:0] sys_clk_sel;
   logic secondary_osc_digital_io;
   logic secondary_osc_low_drive;
   logic secondary_osc_ext_clk;
   logic [2:0] div_q = 3'h0;
   logic [31:0] rdat;
   logic rerr;
   int err_total;
   int cmp_count;

   css_switcher u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .osc_clk(osc_clk), .osc_ready(osc_ready), .secondary_osc_periph_req(secondary_osc_periph_req),
      .clk_fail(clk_fail), .osc_en(osc_en), .sys_clk_sel(sys_clk_sel),
      .secondary_osc_digital_io(secondary_osc_digital_io), .secondary_osc_low_drive(secondary_osc_low_drive),
      .secondary_osc_ext_clk(secondary_osc_ext_clk));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // oscillators run at pclk/8, slow enough for the synchronised edge counter
   always @(posedge pclk) begin
      div_q <= div_q + 3'h1;
      osc_clk <= {5{div_q[2]}};
   end

   task automatic complete_run;
      if (err_total == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: s};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      rdat = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      if (n >= 50) err_total++;
   endtask

   task automatic unlock(input logic hi);
      if (hi) begin
         apb(CSS_OFF_OSC, 1'b1, {16'h0, CSS_KEY_HI1, 8'h00}, 4'h2);
         apb(CSS_OFF_OSC, 1'b1, {16'h0, CSS_KEY_HI2, 8'h00}, 4'h2);
      end else begin
         apb(CSS_OFF_OSC, 1'b1, {24'h0, CSS_KEY_LO1}, 4'h1);
         apb(CSS_OFF_OSC, 1'b1, {24'h0, CSS_KEY_LO2}, 4'h1);
      end
   endtask

   task automatic set_next(input logic [2:0] src);
      unlock(1'b1);
      apb(CSS_OFF_OSC, 1'b1, {21'h0, src, 8'h00}, 4'h2);
   endtask

   task automatic set_low(input logic [7:0] v);
      unlock(1'b0);
      apb(CSS_OFF_OSC, 1'b1, {24'h0, v}, 4'h1);
   endtask

   task automatic rd_osc(input logic [31:0] exp);
      apb(CSS_OFF_OSC, 1'b0, 32'h0, 4'h0);
      chk(rdat, exp);
   endtask

   task automatic t_reset;
      chk({27'h0, osc_en}, 32'h01);
      chk({29'h0, sys_clk_sel}, 32'h0);
      rd_osc(32'h0);
      apb(CSS_OFF_CFG, 1'b0, 32'h0, 4'h0);
      chk(rdat, 32'h63);
      apb(8'h0c, 1'b1, 32'hffff_ffff, 4'hf);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
   endtask

   task automatic t_disabled;
      set_low(8'h01);
      repeat (4) @(posedge pclk);
      rd_osc(32'h0);
      apb(CSS_OFF_CFG, 1'b1, 32'h60, 4'hf);
   endtask

   task automatic t_keys;
      apb(CSS_OFF_OSC, 1'b1, 32'h7800, 4'h2);
      apb(CSS_OFF_OSC, 1'b1, 32'h9b00, 4'h2);
      apb(CSS_OFF_OSC, 1'b1, 32'h0200, 4'h2);
      rd_osc(32'h0);
      unlock(1'b1);
      apb(CSS_OFF_CFG, 1'b0, 32'h0, 4'h0);
      apb(CSS_OFF_OSC, 1'b1, 32'h0200, 4'h2);
      rd_osc(32'h0);
      set_next(CSS_SRC_PRI);
      rd_osc(32'h0200);
      apb(CSS_OFF_OSC, 1'b1, 32'h0001, 4'h1);
      repeat (4) @(posedge pclk);
      rd_osc(32'h0200);
   endtask

   task automatic t_redundant;
      set_next(CSS_SRC_FRC);
      set_low(8'h01);
      repeat (6) @(posedge pclk);
      rd_osc(32'h0);
      chk({29'h0, sys_clk_sel}, 32'h0);
   endtask

   task automatic t_switch;
      int n;
      clk_fail <= 1'b1;
      repeat (3) @(posedge pclk);
      clk_fail <= 1'b0;
      repeat (3) @(posedge pclk);
      rd_osc(32'h0008);
      set_next(CSS_SRC_PRI);
      // bit 3 written as one so only the switch itself may clear the flag
      set_low(8'h09);
      repeat (6) @(posedge pclk);
      rd_osc(32'h0201);
      chk({31'h0, osc_en[CSS_O_PRI]}, 32'h1);
      osc_ready[CSS_O_PRI] <= 1'b1;
      repeat (20) @(posedge pclk);
      chk({29'h0, sys_clk_sel}, 32'h0);
      n = 0;
      while (sys_clk_sel !== CSS_SRC_PRI && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk({29'h0, sys_clk_sel}, {29'h0, CSS_SRC_PRI});
      chk({31'h0, n >= 40}, 32'h1);
      rd_osc(32'h2200);
      chk({27'h0, osc_en}, 32'h0a);
      apb(CSS_OFF_STAT, 1'b0, 32'h0, 4'h0);
      chk(rdat, 32'h0000_020a);
   endtask

   task automatic t_secondary_osc;
      logic [2:0] mexp [4];
      mexp = '{3'h4, 3'h2, 3'h1, 3'h0};
      secondary_osc_periph_req <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({31'h0, osc_en[CSS_O_SEC]}, 32'h1);
      // demand stays high: only the two crystal codes may run the driver
      for (int m = 0; m < 4; m++) begin
         apb(CSS_OFF_CFG, 1'b1, {25'h0, 2'(m), 5'h0}, 4'hf);
         repeat (2) @(posedge pclk);
         chk({29'h0, secondary_osc_digital_io, secondary_osc_low_drive, secondary_osc_ext_clk}, {29'h0, mexp[m]});
         chk({31'h0, osc_en[CSS_O_SEC]},
             {31'h0, 2'(m) == CSS_SMODE_LOWPWR || 2'(m) == CSS_SMODE_RST});
      end
      secondary_osc_periph_req <= 1'b0;
   endtask

   initial begin
      apb_req = '0;
      presetn = 1'b0;
      osc_ready = 5'h00;
      secondary_osc_periph_req = 1'b0;
      clk_fail = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_disabled();
      t_keys();
      t_redundant();
      t_switch();
      t_secondary_osc();
      complete_run();
   end

   // the whole sequence needs a few hundred cycles
   initial begin
      #100us;
      err_total++;
      complete_run();
   end
endmodule

bind css_switcher css_monitor u_mon (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .osc_clk(osc_clk), .osc_ready(osc_ready),
   .secondary_osc_periph_req(secondary_osc_periph_req), .clk_fail(clk_fail), .osc_en(osc_en),
   .sys_clk_sel(sys_clk_sel), .secondary_osc_digital_io(secondary_osc_digital_io),
   .secondary_osc_low_drive(secondary_osc_low_drive), .secondary_osc_ext_clk(secondary_osc_ext_clk));
`default_nettype wire
